// file: dv/sip_tb.sv
// Self-checking bench for the ingress policing register bank.
// Assumes zero-wait APB and the pending-bit table handshake.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sip_pkg::*;

  typedef struct packed {
    logic        chk;
    logic [3:0]  sel;
    logic [32:0] exp;
  } sip_note_t;

  logic              ref_clk_i = 1'b0;
  logic              rst_n_i   = 1'b0;
  logic              psel      = 1'b0;
  logic              penable   = 1'b0;
  logic              pwrite    = 1'b0;
  logic [ADDR_W-1:0] paddr     = '0;
  logic [31:0]       pwdata    = '0;
  logic [1:0]        pkt_port  = '0;
  logic [4:0]        pkt_prio  = '0;
  logic              pkt_nm    = 1'b0;
  logic              pkt_act   = 1'b0;
  logic              probe     = 1'b0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              pkt_admit_o;
  logic [2:0]        bcst_enable_o;
  logic [23:0]       bcst_level_o;
  logic              meter_enable_o;
  logic [1:0]        meter_mode_o;
  logic [15:0]       meter_cir_o;
  logic [15:0]       meter_cbs_o;
  logic [15:0]       meter_ebs_o;
  int                error_cnt = 0;
  int                n_checks  = 0;
  sip_note_t         notes[$];
  sip_note_t         nt;
  logic [15:0]       committed_rate_entry[24];
  logic [31:0]       v;
  logic [31:0]       d;
  string             nm[9] = '{"apb", "bcst_en", "bcst_lvl", "admit",
                              "meter_en", "mode", "cir", "cbs", "ebs"};

  sip_regs dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_port_i(pkt_port), .pkt_prio_i(pkt_prio),
    .pkt_nonmember_i(pkt_nm), .pkt_vlan_active_i(pkt_act),
    .pkt_admit_o(pkt_admit_o), .bcst_enable_o(bcst_enable_o),
    .bcst_level_o(bcst_level_o), .meter_enable_o(meter_enable_o),
    .meter_mode_o(meter_mode_o), .meter_cir_o(meter_cir_o),
    .meter_cbs_o(meter_cbs_o), .meter_ebs_o(meter_ebs_o));

  initial begin
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [32:0] e,
                       input logic [32:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask

  function automatic logic [32:0] seen(input logic [3:0] s);
    case (s)
      4'h0: seen = {pslverr, pwrite ? 32'h0 : prdata};
      4'h1: seen = {30'h0, bcst_enable_o};
      4'h2: seen = {9'h0, bcst_level_o};
      4'h3: seen = {32'h0, pkt_admit_o};
      4'h4: seen = {32'h0, meter_enable_o};
      4'h5: seen = {31'h0, meter_mode_o};
      4'h6: seen = {17'h0, meter_cir_o};
      4'h7: seen = {17'h0, meter_cbs_o};
      default: seen = {17'h0, meter_ebs_o};
    endcase
  endfunction

  // ***************************************************
  // Monitor: pops the oldest note at each result
  // ***************************************************
  always @(posedge ref_clk_i) begin
    if ((psel && penable && pready) || probe) begin
      if (notes.size() == 0) begin
        check("note queue", 33'h1, 33'h0);
      end else begin
        nt = notes.pop_front();
        if (nt.chk) begin
          check(nm[nt.sel], nt.exp, seen(nt.sel));
        end
      end
    end
  end

  // ***************************************************
  // Drivers
  // ***************************************************
  // No release at the end, so transfers run back to back
  task automatic apb(input logic wr, input logic [15:0] idx,
                     input logic [31:0] wd, input logic [32:0] e,
                     input logic c, output logic [31:0] rd);
    int k;
    notes.push_back('{c, 4'h0, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
    rd = prdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd, 33'h0, 1'b1, d);
  endtask

  task automatic rd(input logic [15:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0, {1'b0, e}, 1'b1, d);
  endtask

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic chk_port(input logic [3:0] s, input logic [32:0] e);
    notes.push_back('{1'b1, s, e});
    probe <= 1'b1;
    @(posedge ref_clk_i);
    probe <= 1'b0;
    @(posedge ref_clk_i);
  endtask

  task automatic pkt(input int p, input int q, input logic n,
                     input logic a);
    pkt_port <= p[1:0];
    pkt_prio <= q[4:0];
    pkt_nm <= n;
    pkt_act <= a;
  endtask

  task automatic tcmd(input logic [7:0] c);
    int k;
    wr(IDX_METER_CMD, {$urandom() & 32'hffffff00} | c);
    apb(1'b0, IDX_METER_STS, 32'h0, 33'h1, 1'b1, d);
    k = 0;
    do begin
      apb(1'b0, IDX_METER_STS, 32'h0, 33'h0, 1'b0, d);
      k++;
    end while (d[0] !== 1'b0 && k < 20);
    if (d[0] !== 1'b0) begin
      error_cnt++;
      finish_test();
    end
  endtask

  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    void'($urandom(50));
    repeat (20) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    rd(IDX_BCST_THROT, 32'h00080402);
    rd(IDX_ADMIT_NM, 32'h0);
    rd(IDX_METER_CFG, 32'h0);
    rd(IDX_METER_STS, 32'h0);
    idle();
    chk_port(4'h6, {17'h0, CIR_RST});
    chk_port(4'h7, 33'h0600);
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 32'hffffffff : $urandom();
      wr(IDX_BCST_THROT, v);
      rd(IDX_BCST_THROT, v & 32'h07ffffff);
      idle();
      chk_port(4'h1, {30'h0, v[26], v[17], v[8]});
      chk_port(4'h2, {9'h0, v[25:18], v[16:9], v[7:0]});
    end
    for (int i = 0; i < 2; i++) begin
      v = $urandom();
      wr(IDX_ADMIT_NM, v);
      rd(IDX_ADMIT_NM, v & 32'h7);
      idle();
      for (int p = 0; p < 3; p++) begin
        for (int c = 0; c < 4; c++) begin
          pkt(p, 0, c[0], c[1]);
          chk_port(4'h3, {32'h0, c[1] & (~c[0] | v[p])});
        end
      end
    end
    // Random table contents so each key picks a distinct value
    for (int i = 0; i < 24; i++) begin
      committed_rate_entry[i] = 16'($urandom());
      wr(IDX_METER_WDATA, {16'hffff, committed_rate_entry[i]});
      tcmd({3'b001, i[4:0]});
    end
    rd(IDX_METER_WDATA, {16'h0, committed_rate_entry[23]});
    for (int t = 2; t < 4; t++) begin
      wr(IDX_METER_WDATA, 32'h00001230 | t);
      tcmd({1'b0, t[1:0], 5'h0});
      tcmd({1'b1, t[1:0], 5'h0});
      rd(IDX_METER_RDATA, 32'h00001230 | t);
    end
    for (int i = 0; i < 24; i += 23) begin
      tcmd({3'b101, i[4:0]});
      rd(IDX_METER_CMD, {24'h0, 3'b101, i[4:0]});
      rd(IDX_METER_RDATA, {16'h0, committed_rate_entry[i]});
    end
    idle();
    chk_port(4'h7, 33'h1232);
    chk_port(4'h8, 33'h1233);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_METER_CFG, ($urandom() & 32'hfffffff8) | (m * 2) | m[0]);
      rd(IDX_METER_CFG, (m * 2) | m[0]);
      idle();
      chk_port(4'h4, {32'h0, m[0]});
      chk_port(4'h5, {31'h0, m[1:0]});
      for (int q = 0; q < 24; q++) begin
        if (m == 0 && q < 8) begin
          for (int p = 0; p < 3; p++) begin
            pkt(p, q, 1'b0, 1'b1);
            chk_port(4'h6, {17'h0, committed_rate_entry[8 * p + q]});
          end
        end else if (m == 1 && q < 3) begin
          pkt(q, 5, 1'b0, 1'b1);
          chk_port(4'h6, {17'h0, committed_rate_entry[q]});
        end else if (m == 2) begin
          pkt(q % 3, q, 1'b0, 1'b1);
          chk_port(4'h6, {17'h0, committed_rate_entry[q]});
        end else if (m == 3 && q == 0) begin
          pkt(2, 9, 1'b0, 1'b1);
          chk_port(4'h6, {17'h0, committed_rate_entry[0]});
        end
      end
    end
    apb(1'b1, 16'h1850, 32'h1, 33'h100000000, 1'b1, d);
    apb(1'b0, 16'h1850, 32'h0, 33'h100000000, 1'b1, d);
    idle();
    repeat (2) @(posedge ref_clk_i);
    if (notes.size() != 0) begin
      error_cnt++;
    end
    finish_test();
  end
endmodule
`default_nettype wire

// file: verilog/sip_meter_table.sv
// Indirect metering table: 24 rate entries plus two burst sizes.
// Assumes one command pulse at a time from the register bank.
`timescale 1ns/1ps
`default_nettype none
module sip_meter_table
  import sip_pkg::*;
#(
  parameter int ENTRIES = CIR_ENTRIES
) (
  input  wire logic                ref_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                start_i,
  input  wire sip_cmd_t            cmd_i,
  input  wire logic [ENTRY_W-1:0]  wdata_i,
  input  wire logic [4:0]          lookup_idx_i,
  output logic                     done_o,
  output logic [ENTRY_W-1:0]       rdata_o,
  output logic [ENTRY_W-1:0]       lookup_cir_o,
  output logic [ENTRY_W-1:0]       cbs_o,
  output logic [ENTRY_W-1:0]       ebs_o
);

  logic [ENTRY_W-1:0] committed_rate_entry [ENTRIES];
  logic               busy;
  sip_cmd_t           cmd_q;
  wire logic          addr_ok  = int'(cmd_q.addr) < ENTRIES;
  wire logic          look_ok  = int'(lookup_idx_i) < ENTRIES;
  wire logic          do_write = busy && !cmd_q.dir_read;

  // ***************************************************
  // Rate entries
  // ***************************************************
  // Out-of-range addresses are dropped so reset values stay intact
  for (genvar g = 0; g < ENTRIES; g++) begin : g_cir
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        committed_rate_entry[g] <= CIR_RST; // see R20
      end else if (do_write && cmd_q.target == SIP_TGT_CIR &&
                   int'(cmd_q.addr) == g) begin
        committed_rate_entry[g] <= wdata_i; // see R11
      end
    end
  end

  // ***************************************************
  // Burst sizes, read path, completion
  // ***************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cbs_o   <= BURST_RST;
      ebs_o   <= BURST_RST;
      busy    <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= '0;
      cmd_q   <= '0;
    end else begin
      busy   <= start_i;
      done_o <= busy;
      if (start_i) begin
        cmd_q <= cmd_i;
      end
      if (do_write && cmd_q.target == SIP_TGT_CBS) begin
        cbs_o <= wdata_i; // see R10
      end
      if (do_write && cmd_q.target == SIP_TGT_EBS) begin
        ebs_o <= wdata_i;
      end
      if (busy && cmd_q.dir_read) begin // see R09
        case (cmd_q.target)
          SIP_TGT_CIR: rdata_o <= addr_ok ? committed_rate_entry[cmd_q.addr] : '0;
          SIP_TGT_CBS: rdata_o <= cbs_o;
          SIP_TGT_EBS: rdata_o <= ebs_o;
          default:     rdata_o <= '0;
        endcase
      end
    end
  end

  assign lookup_cir_o = look_ok ? committed_rate_entry[lookup_idx_i] : '0; // see R19

  cmd_done_a: assert property ( // see R18
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    start_i |-> ##2 done_o) else $error("table op did not finish");

endmodule
`default_nettype wire

// file: verilog/sip_pkg.sv
// Package for the switch ingress policing register bank.
// Assumes a 32-bit APB slave at 25 MHz, word-aligned registers.
package sip_pkg;

  // ***************************************************
  // Register indexes and addressing
  // ***************************************************
  localparam logic [15:0] IDX_BCST_THROT  = 16'h1848;
  localparam logic [15:0] IDX_ADMIT_NM    = 16'h1849;
  localparam logic [15:0] IDX_METER_CFG   = 16'h184a;
  localparam logic [15:0] IDX_METER_CMD   = 16'h184b;
  localparam logic [15:0] IDX_METER_STS   = 16'h184c;
  localparam logic [15:0] IDX_METER_WDATA = 16'h184d;
  localparam logic [15:0] IDX_METER_RDATA = 16'h184e;
  localparam int          ADDR_W          = 18;
  localparam int          IDX_LSB         = 2;

  // ***************************************************
  // Field layout and reset values
  // ***************************************************
  localparam int          NUM_PORTS       = 3;
  localparam int          PORT_STRIDE     = 9;
  localparam int          LEVEL_W         = 8;
  localparam int          EN_BIT_OFS      = 8;
  localparam logic [7:0]  LEVEL_RST       = 8'h02;
  localparam int          CIR_ENTRIES     = 24;
  localparam int          ENTRY_W         = 16;
  localparam logic [15:0] CIR_RST         = 16'h0014;
  localparam logic [15:0] BURST_RST       = 16'h0600;
  localparam int          CMD_DIR_BIT     = 7;
  localparam int          CMD_TYPE_LSB    = 5;
  localparam int          CMD_ADDR_W      = 5;
  localparam int          CFG_EN_BIT      = 0;
  localparam int          CFG_MODE_LSB    = 1;
  localparam int          RATE_UNIT_NS    = 20;
  localparam int          BCST_UNIT_BYTES = 64;
  localparam int          BCST_INTERVAL_US = 1720;
  localparam int          CLK_MHZ         = 25;
  localparam int          BCST_INTERVAL_CYC = BCST_INTERVAL_US * CLK_MHZ;

  typedef enum logic [1:0] {
    SIP_MODE_PORT_PRI = 2'h0,
    SIP_MODE_PORT     = 2'h1,
    SIP_MODE_PRI      = 2'h2,
    SIP_MODE_RSVD     = 2'h3
  } sip_mode_t;

  typedef enum logic [1:0] {
    SIP_TGT_RSVD = 2'h0,
    SIP_TGT_CIR  = 2'h1,
    SIP_TGT_CBS  = 2'h2,
    SIP_TGT_EBS  = 2'h3
  } sip_target_t;

  typedef struct packed {
    logic        dir_read;
    sip_target_t target;
    logic [4:0]  addr;
  } sip_cmd_t;

  typedef struct packed {
    logic       enable;
    logic [7:0] level;
  } sip_throttle_t;

endpackage

// file: verilog/sip_regs.sv
// Switch ingress policing register bank, APB slave, 25 MHz.
// Assumes software keeps one table command outstanding at a time.
//
// Contract
// R01 - Per-port broadcast throttle enable bits 26/17/8
// R02 - Throttle level 64-byte units, resets to 2
// R03 - Level fields 25:18, 16:9, 7:0; top reserved
// R04 - Admit-nonmember bit per ingress port
// R05 - Nonmember admission needs active destination VLAN
// R06 - Mode field selects metering key
// R07 - Enable bit gates metering and dropping
// R08 - Command write launches table access
// R09 - Bit 7 picks read or write
// R10 - Type field picks rate/committed/excess entry
// R11 - Five-bit address picks rate entry
// R12 - Port-priority mode: eight entries per port
// R13 - Port-only mode: entry equals port
// R14 - Priority-only mode: entry equals priority
// R15 - Software reads data after pending clears
// R16 - Software loads write data before command
// R17 - Software keeps address in range
// R18 - Pending bit set during access, self-clears
// R19 - Table: 24 rate entries plus two bursts
// R20 - Rate entry is time per byte, reset 0014h
// R21 - No new command while pending
`timescale 1ns/1ps
`default_nettype none
module sip_regs
  import sip_pkg::*;
(
  input  wire logic               ref_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [ADDR_W-1:0]  paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [1:0]         pkt_port_i,
  input  wire logic [4:0]         pkt_prio_i,
  input  wire logic               pkt_nonmember_i,
  input  wire logic               pkt_vlan_active_i,
  output logic                    pkt_admit_o,
  output logic [NUM_PORTS-1:0]    bcst_enable_o,
  output logic [NUM_PORTS*8-1:0]  bcst_level_o,
  output logic                    meter_enable_o,
  output logic [1:0]              meter_mode_o,
  output logic [ENTRY_W-1:0]      meter_cir_o,
  output logic [ENTRY_W-1:0]      meter_cbs_o,
  output logic [ENTRY_W-1:0]      meter_ebs_o
);

  // ***************************************************
  // Address decode
  // ***************************************************
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [15:0] idx);
    hit = a[ADDR_W-1:IDX_LSB] == idx;
  endfunction

  wire logic access   = psel && penable;
  wire logic wr_acc   = access && pwrite;
  wire logic hit_bt   = hit(paddr, IDX_BCST_THROT);
  wire logic hit_an   = hit(paddr, IDX_ADMIT_NM);
  wire logic hit_cfg  = hit(paddr, IDX_METER_CFG);
  wire logic hit_cmd  = hit(paddr, IDX_METER_CMD);
  wire logic hit_sts  = hit(paddr, IDX_METER_STS);
  wire logic hit_wd   = hit(paddr, IDX_METER_WDATA);
  wire logic hit_rd   = hit(paddr, IDX_METER_RDATA);
  wire logic mapped   = hit_bt | hit_an | hit_cfg | hit_cmd |
                        hit_sts | hit_wd | hit_rd;

  // ***************************************************
  // Register storage
  // ***************************************************
  sip_throttle_t              thr [NUM_PORTS];
  logic [NUM_PORTS-1:0]       admit_nm;
  logic                       meter_en;
  logic [1:0]                 meter_mode;
  sip_cmd_t                   cmd;
  logic [ENTRY_W-1:0]         wdata;
  logic                       pending;
  logic                       start;
  logic                       done;
  logic [ENTRY_W-1:0]         tbl_rdata;
  logic [4:0]                 lookup_idx;
  logic [31:0]                bt_word;
  logic [31:0]                next_prdata;

  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    localparam int LSB = p * PORT_STRIDE;
    always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
        thr[p] <= '{enable: 1'b0, level: LEVEL_RST}; // see R02
      end else if (wr_acc && hit_bt) begin
        thr[p].enable <= pwdata[LSB+EN_BIT_OFS]; // see R01
        thr[p].level  <= pwdata[LSB +: LEVEL_W]; // see R03
      end
    end
    assign bt_word[LSB +: PORT_STRIDE] = {thr[p].enable, thr[p].level};
    assign bcst_enable_o[p]            = thr[p].enable;
    assign bcst_level_o[p*LEVEL_W +: LEVEL_W] = thr[p].level;
  end
  assign bt_word[31:NUM_PORTS*PORT_STRIDE] = '0; // see R03

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      admit_nm   <= '0;
      meter_en   <= 1'b0;
      meter_mode <= SIP_MODE_PORT_PRI;
      cmd        <= '0;
      wdata      <= '0;
    end else begin
      if (wr_acc && hit_an) begin
        admit_nm <= pwdata[NUM_PORTS-1:0];
      end
      if (wr_acc && hit_cfg) begin
        meter_en   <= pwdata[CFG_EN_BIT];
        meter_mode <= pwdata[CFG_MODE_LSB +: 2];
      end
      if (wr_acc && hit_cmd) begin
        cmd <= pwdata[CMD_DIR_BIT:0];
      end
      if (wr_acc && hit_wd) begin
        wdata <= pwdata[ENTRY_W-1:0];
      end
    end
  end

  // ***************************************************
  // Command launch and pending flag
  // ***************************************************
  // Start fires only on the completing APB edge, so one write = one op
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      start   <= 1'b0;
      pending <= 1'b0;
    end else begin
      start <= wr_acc && hit_cmd; // see R08
      if (wr_acc && hit_cmd) begin
        pending <= 1'b1; // see R18
      end else if (done) begin
        pending <= 1'b0;
      end
    end
  end

  sip_meter_table #(
    .ENTRIES (CIR_ENTRIES)
  ) u_table (
    .ref_clk_i    (ref_clk_i),
    .rst_n_i      (rst_n_i),
    .start_i      (start),
    .cmd_i        (cmd),
    .wdata_i      (wdata),
    .lookup_idx_i (lookup_idx),
    .done_o       (done),
    .rdata_o      (tbl_rdata),
    .lookup_cir_o (meter_cir_o),
    .cbs_o        (meter_cbs_o),
    .ebs_o        (meter_ebs_o)
  );

  // ***************************************************
  // Metering key and admission
  // ***************************************************
  // Reserved mode yields entry 0 rather than an undefined index
  wire logic [4:0] key_port_pri = 5'({pkt_port_i, 3'h0}) +
                                  5'({2'h0, pkt_prio_i[2:0]});
  assign lookup_idx =
      (meter_mode == SIP_MODE_PORT_PRI) ? key_port_pri :          // see R12
      (meter_mode == SIP_MODE_PORT)     ? {3'h0, pkt_port_i} :    // see R13
      (meter_mode == SIP_MODE_PRI)      ? pkt_prio_i : 5'h00;     // see R14

  wire logic port_ok = int'(pkt_port_i) < NUM_PORTS;
  wire logic nm_ok   = port_ok && admit_nm[pkt_port_i];         // see R04
  assign pkt_admit_o = pkt_vlan_active_i &&
                       (!pkt_nonmember_i || nm_ok);             // see R05
  assign meter_enable_o = meter_en;                              // see R07
  assign meter_mode_o   = meter_mode;                            // see R06

  // ***************************************************
  // APB read path
  // ***************************************************
  always_comb begin
    next_prdata = '0;
    if (hit_bt) begin
      next_prdata = bt_word;
    end else if (hit_an) begin
      next_prdata = {29'h0, admit_nm};
    end else if (hit_cfg) begin
      next_prdata = {29'h0, meter_mode, meter_en};
    end else if (hit_cmd) begin
      next_prdata = {24'h0, cmd};
    end else if (hit_sts) begin
      next_prdata = {31'h0, pending};
    end else if (hit_wd) begin
      next_prdata = {16'h0, wdata};
    end else if (hit_rd) begin
      next_prdata = {16'h0, tbl_rdata};
    end
  end

  // Read data is registered in the setup cycle, valid at access phase
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // ***************************************************
  // Checks
  // ***************************************************
  // Pending stays up through the clear edge, so it reads 1 for three edges
  pend_set_a: assert property ( // see R18
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_cmd |=> pending [*3] ##1 !pending)
    else $error("pending bit timing wrong");
  pend_hold_a: assert property ( // see R18
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pending && !done |=> pending)
    else $error("pending dropped early");
  pend_clear_a: assert property ( // see R18
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    done && !(wr_acc && hit_cmd) |=> !pending)
    else $error("pending not cleared");
  sts_read_a: assert property ( // see R18
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    psel && !penable && !pwrite && hit_sts |=> prdata == {31'h0, $past(pending)})
    else $error("status readback wrong");
  launch_once_a: assert property ( // see R08
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    start |-> $past(wr_acc && hit_cmd))
    else $error("table op without command write");
  start_pulse_a: assert property ( // see R08
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_cmd |=> start)
    else $error("command write did not launch");
  cmd_store_a: assert property ( // see R09
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_cmd |=> cmd == $past(pwdata[7:0]))
    else $error("command fields not stored");
  admit_vlan_a: assert property ( // see R05
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !pkt_vlan_active_i |-> !pkt_admit_o)
    else $error("admitted to inactive vlan");
  admit_member_a: assert property ( // see R05
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pkt_vlan_active_i && !pkt_nonmember_i |-> pkt_admit_o)
    else $error("member packet refused");
  admit_nm_a: assert property ( // see R04
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    pkt_vlan_active_i && pkt_nonmember_i && port_ok
      |-> pkt_admit_o == admit_nm[pkt_port_i])
    else $error("nonmember admission wrong");
  nm_store_a: assert property ( // see R04
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_an |=> admit_nm == $past(pwdata[2:0]))
    else $error("admit bits not stored");
  key_port_a: assert property ( // see R13
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    meter_mode == SIP_MODE_PORT |-> lookup_idx == {3'h0, pkt_port_i})
    else $error("port-only key wrong");
  key_pri_a: assert property ( // see R14
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    meter_mode == SIP_MODE_PRI |-> lookup_idx == pkt_prio_i)
    else $error("priority-only key wrong");
  key_group_a: assert property ( // see R12
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    meter_mode == SIP_MODE_PORT_PRI
      |-> lookup_idx[4:3] == pkt_port_i && lookup_idx[2:0] == pkt_prio_i[2:0])
    else $error("port-priority key wrong");
  key_rsvd_a: assert property ( // see R06
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    meter_mode == SIP_MODE_RSVD |-> lookup_idx == 5'h00)
    else $error("reserved mode key wrong");
  cfg_mode_a: assert property ( // see R06
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_cfg |=> meter_mode_o == $past(pwdata[2:1]))
    else $error("meter mode not stored");
  bt_write_a: assert property ( // see R01
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_bt |=> bcst_enable_o[2] == $past(pwdata[26]) &&
      bcst_level_o[23:16] == $past(pwdata[25:18]))
    else $error("throttle field placement wrong");
  bt_port1_a: assert property ( // see R03
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_bt |=> bcst_enable_o[1] == $past(pwdata[17]) &&
      bcst_level_o[15:8] == $past(pwdata[16:9]))
    else $error("port 1 throttle field wrong");
  bt_port0_a: assert property ( // see R01
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_bt |=> bcst_enable_o[0] == $past(pwdata[8]) &&
      bcst_level_o[7:0] == $past(pwdata[7:0]))
    else $error("port 0 throttle field wrong");
  bt_rsvd_a: assert property ( // see R03
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    psel && !penable && !pwrite && hit_bt |=> prdata[31:27] == 5'h00)
    else $error("reserved throttle bits not zero");
  cfg_en_a: assert property ( // see R07
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_acc && hit_cfg |=> meter_enable_o == $past(pwdata[0]))
    else $error("meter enable not stored");

endmodule
`default_nettype wire
